//--- rtl/spi_regs_pkg.sv
// constants shared by the serial register access slave
//
// Function
// - device only answers as a slave; idles until a master selects it.
// - mode 0: clock idles low, incoming bits sampled on rising edges.
// - at least 5 us between bytes; device loads next outgoing byte then.
// - first byte is the operation: 0x00 reads, 0x01 writes.
// - second byte is the register address of the transaction.
// - read returns the addressed 32-bit register over four bytes, MSB first.
// - address sent during last read byte chains another four-byte read.
// - write captures four following bytes into the addressed register.
// - device holds its data-out low while accepting write data, except for a write to 0xAA, where it returns the version.
// - one register per write transaction; no chained writes.
// - all-zero write to a command address runs the command, stores nothing.
// - commands give no answer, except version query at 0xAA returns version.
// - all-zero write to 0xAC recalibrates the rate gyro zero point.
package spi_regs_pkg;

  // ****************************************
  // transaction encodings
  // ****************************************
  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_WRITE = 8'h01;
  localparam logic [7:0] ADDR_FW_VERSION = 8'hAA;
  localparam logic [7:0] ADDR_GYRO_ZERO = 8'hAC;
  // addresses at or above this one are commands
  localparam logic [7:0] CMD_ADDR_BASE = 8'hAA;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************
  // framing
  // ****************************************
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [1:0] DATA_IDX_FIRST = 2'h0;
  localparam logic [1:0] DATA_IDX_LAST = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_NS = 10;
  localparam int BYTE_GAP_NS = 5000;
  localparam int BYTE_GAP_CYC = (BYTE_GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [9:0] GAP_CNT_MAX = 10'(BYTE_GAP_CYC);
  localparam logic [1:0] FETCH_CYC = 2'h2;

  typedef enum logic [2:0] {
    ST_OP = 3'b000,
    ST_ADDR = 3'b001,
    ST_RDATA = 3'b011,
    ST_WDATA = 3'b010,
    ST_HOLD = 3'b110
  } xfer_state_t;

endpackage

//--- rtl/spi_register_access_slave.sv
// serial register access slave: link shifter on the serial clock, protocol on clk
`timescale 1ns/1ns
`default_nettype none

module spi_register_access_slave
  import spi_regs_pkg::*;
#(
  // arbitrary value
  parameter logic [31:0] FW_VERSION = 32'h0000_0001
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output var logic miso,
  output var logic miso_oe,
  output var logic [7:0] reg_addr,
  input wire logic [31:0] rd_data,
  output var logic [31:0] reg_wdata,
  output var logic reg_wr,
  output var logic cmd_strobe,
  output var logic gyro_zero_strobe,
  output var logic gap_err
);

  // ****************************************
  // link side, clocked by the serial clock
  // ****************************************
  // deselect clears the bit counter so the next frame opens on an operation byte
  logic link_rst_n;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [2:0] bit_gray_r;
  logic [7:0] rx_sh_r;

  assign link_rst_n = nrst & ~ss_n;
  assign bit_cnt_nxt = bit_cnt_r + 3'h1;

  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_r <= BIT_FIRST;
      bit_gray_r <= BIT_FIRST;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      bit_gray_r <= bit_cnt_nxt ^ (bit_cnt_nxt >> 1);
    end
  end

  // sample on rise
  // the byte stays put after the eighth edge until the next frame bit, which the
  // master delays by the byte gap, so clk may read it once the count has crossed
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      rx_sh_r <= BYTE_ZERO;
    end else begin
      rx_sh_r <= {rx_sh_r[6:0], mosi};
    end
  end

  // ****************************************
  // crossings into clk
  // ****************************************
  logic ss_meta_r;
  logic ss_sync_r;
  logic [2:0] gray_meta_r;
  logic [2:0] gray_sync_r;
  logic [2:0] cnt_bin;
  logic [2:0] cnt_prev_r;
  logic sel;
  logic byte_done;
  logic byte_start;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ss_meta_r <= 1'b1;
      ss_sync_r <= 1'b1;
    end else begin
      ss_meta_r <= ss_n;
      ss_sync_r <= ss_meta_r;
    end
  end

  // count is gray coded, so a sample caught mid-change is off by one at most
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gray_meta_r <= BIT_FIRST;
      gray_sync_r <= BIT_FIRST;
      cnt_prev_r <= BIT_FIRST;
    end else begin
      gray_meta_r <= bit_gray_r;
      gray_sync_r <= gray_meta_r;
      cnt_prev_r <= cnt_bin;
    end
  end

  assign cnt_bin = {gray_sync_r[2],
                    gray_sync_r[2] ^ gray_sync_r[1],
                    gray_sync_r[2] ^ gray_sync_r[1] ^ gray_sync_r[0]};
  assign sel = ~ss_sync_r;
  assign byte_done = sel && (cnt_prev_r == BIT_LAST) && (cnt_bin == BIT_FIRST);
  assign byte_start = sel && (cnt_prev_r == BIT_FIRST) && (cnt_bin != BIT_FIRST);

  // ****************************************
  // protocol state
  // ****************************************
  xfer_state_t state_r;
  logic [1:0] data_idx_r;
  logic [31:0] data_r;
  logic [7:0] tx_byte_r;
  logic [1:0] fetch_cnt_r;
  logic fetch_busy_r;
  logic [7:0] rx_byte;
  logic [31:0] wdata_full;
  logic is_cmd;
  logic is_write_r;
  logic step;
  logic addr_done;
  logic rd_last;
  logic fetch_start;
  logic fetch_done;

  assign rx_byte = rx_sh_r;
  assign wdata_full = {data_r[23:0], rx_byte};
  assign is_cmd = (reg_addr >= CMD_ADDR_BASE) && (wdata_full == 32'h0000_0000);
  // a byte that ends while a fetch is running is not decoded
  assign step = byte_done && !fetch_busy_r;
  assign addr_done = step && (state_r == ST_ADDR);
  assign rd_last = step && (state_r == ST_RDATA) && (data_idx_r == DATA_IDX_LAST);
  assign fetch_start = (addr_done && !is_write_r) || rd_last;
  assign fetch_done = sel && fetch_busy_r && (fetch_cnt_r == 2'h0);

  // ****************************************
  // transfer sequencing
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_OP;
    end else if (!sel) begin
      state_r <= ST_OP;
    end else if (step) begin
      case (state_r)
        ST_OP: begin
          if (rx_byte == OP_READ || rx_byte == OP_WRITE) begin
            state_r <= ST_ADDR;
          end else begin
            state_r <= ST_HOLD;
          end
        end
        ST_ADDR: begin
          state_r <= is_write_r ? ST_WDATA : ST_RDATA;
        end
        ST_WDATA: begin
          if (data_idx_r == DATA_IDX_LAST) begin
            state_r <= ST_HOLD;
          end
        end
        ST_RDATA: begin
          state_r <= ST_RDATA;
        end
        ST_HOLD: begin
          state_r <= ST_HOLD;
        end
        default: begin
          state_r <= ST_OP;
        end
      endcase
    end
  end

  // direction of the running transfer, kept from the operation byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      is_write_r <= 1'b0;
    end else if (!sel) begin
      is_write_r <= 1'b0;
    end else if (step && (state_r == ST_OP)) begin
      is_write_r <= (rx_byte == OP_WRITE);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_addr <= BYTE_ZERO;
    end else if (addr_done || rd_last) begin
      reg_addr <= rx_byte;
    end
  end

  // read data is fetched inside the byte gap, before the next frame bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_busy_r <= 1'b0;
      fetch_cnt_r <= 2'h0;
    end else if (!sel) begin
      fetch_busy_r <= 1'b0;
      fetch_cnt_r <= 2'h0;
    end else if (fetch_busy_r) begin
      if (fetch_cnt_r == 2'h0) begin
        fetch_busy_r <= 1'b0;
      end else begin
        fetch_cnt_r <= fetch_cnt_r - 2'h1;
      end
    end else if (fetch_start) begin
      fetch_busy_r <= 1'b1;
      fetch_cnt_r <= FETCH_CYC;
    end
  end

  // position of the data byte inside the 32-bit word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_idx_r <= DATA_IDX_FIRST;
    end else if (!sel) begin
      data_idx_r <= DATA_IDX_FIRST;
    end else if (addr_done || rd_last) begin
      data_idx_r <= DATA_IDX_FIRST;
    end else if (step && (state_r == ST_RDATA || state_r == ST_WDATA) &&
                 (data_idx_r != DATA_IDX_LAST)) begin
      data_idx_r <= data_idx_r + 2'h1;
    end
  end

  // word being shifted out on a read or gathered on a write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_r <= 32'h0000_0000;
    end else if (fetch_done) begin
      data_r <= rd_data;
    end else if (addr_done && is_write_r) begin
      data_r <= 32'h0000_0000;
    end else if (step && (state_r == ST_RDATA) && (data_idx_r != DATA_IDX_LAST)) begin
      data_r <= {data_r[23:0], BYTE_ZERO};
    end else if (step && (state_r == ST_WDATA)) begin
      data_r <= wdata_full;
    end
  end

  // next outgoing byte, loaded in the gap before its first bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_byte_r <= BYTE_ZERO;
    end else if (!sel) begin
      tx_byte_r <= BYTE_ZERO;
    end else if (fetch_done) begin
      tx_byte_r <= rd_data[31:24];
    end else if (step) begin
      case (state_r)
        ST_OP: begin
          tx_byte_r <= BYTE_ZERO;
        end
        ST_ADDR: begin
          if (is_write_r && rx_byte == ADDR_FW_VERSION) begin
            tx_byte_r <= FW_VERSION[31:24];
          end else begin
            tx_byte_r <= BYTE_ZERO;
          end
        end
        ST_RDATA: begin
          if (data_idx_r != DATA_IDX_LAST) begin
            tx_byte_r <= data_r[23:16];
          end
        end
        ST_WDATA: begin
          if (data_idx_r != DATA_IDX_LAST && reg_addr == ADDR_FW_VERSION) begin
            tx_byte_r <= FW_VERSION[(23 - 8 * 32'(data_idx_r)) -: 8];
          end else begin
            tx_byte_r <= BYTE_ZERO;
          end
        end
        ST_HOLD: begin
          tx_byte_r <= BYTE_ZERO;
        end
        default: begin
          tx_byte_r <= BYTE_ZERO;
        end
      endcase
    end
  end

  // ****************************************
  // write and command strobes
  // ****************************************
  logic wr_last;

  assign wr_last = byte_done && !fetch_busy_r && (state_r == ST_WDATA) &&
                   (data_idx_r == DATA_IDX_LAST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_wr <= 1'b0;
      reg_wdata <= 32'h0000_0000;
      cmd_strobe <= 1'b0;
      gyro_zero_strobe <= 1'b0;
    end else begin
      reg_wr <= wr_last && !is_cmd;
      cmd_strobe <= wr_last && is_cmd;
      gyro_zero_strobe <= wr_last && is_cmd && (reg_addr == ADDR_GYRO_ZERO);
      if (wr_last) begin
        reg_wdata <= wdata_full;
      end
    end
  end

  // ****************************************
  // byte gap watch
  // ****************************************
  // a frame bit that starts too soon may shift out a stale byte; flag it
  logic [9:0] gap_cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_cnt_r <= GAP_CNT_MAX;
      gap_err <= 1'b0;
    end else begin
      gap_err <= byte_start && (gap_cnt_r != GAP_CNT_MAX);
      if (byte_done) begin
        gap_cnt_r <= 10'h000;
      end else if (gap_cnt_r != GAP_CNT_MAX) begin
        gap_cnt_r <= gap_cnt_r + 10'h001;
      end
    end
  end

  // ****************************************
  // data-out pin
  // ****************************************
  // the bit is picked by the crossed count: it settles tens of ns after each
  // rising edge, well before the next one at the highest allowed clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= sel;
      miso <= sel && tx_byte_r[~cnt_bin];
    end
  end

endmodule

`default_nettype wire

//--- verification/spi_slave_sva.sv
// assertions on the slave's ports
`timescale 1ns/1ns
`default_nettype none
module spi_slave_sva
  import spi_regs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ss_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic cmd_strobe,
  input wire logic gyro_zero_strobe,
  input wire logic gap_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_OE_IDLE: assert property (ss_n [*5] |-> !miso_oe) else $error("oe idle");
  AST_MISO_QUIET: assert property (!miso_oe |-> !miso) else $error("miso idle");
  AST_WR_PULSE: assert property (reg_wr |=> !reg_wr) else $error("wr pulse");
  AST_GYRO_CMD: assert property (gyro_zero_strobe |-> cmd_strobe && reg_addr == ADDR_GYRO_ZERO)
    else $error("gyro strobe");
  AST_CMD_GYRO: assert property (cmd_strobe && reg_addr == ADDR_GYRO_ZERO |-> gyro_zero_strobe)
    else $error("gyro missing");
  AST_CMD_ZERO: assert property (cmd_strobe |-> reg_addr >= CMD_ADDR_BASE && reg_wdata == 32'h0
    && !reg_wr) else $error("cmd strobe");
  AST_WR_NOT_CMD: assert property (reg_wr |-> !(reg_addr >= CMD_ADDR_BASE && reg_wdata == 32'h0))
    else $error("cmd stored");
  AST_IDLE: assert property (ss_n [*8] |-> !reg_wr && !cmd_strobe && !gap_err)
    else $error("idle activity");
  AST_ADDR_HOLD: assert property (ss_n [*8] |=> $stable(reg_addr)) else $error("addr moved");
  AST_GAP_PULSE: assert property (gap_err |=> !gap_err) else $error("gap pulse");
  cover property (reg_wr);
  cover property (gyro_zero_strobe);
  cover property (gap_err);
endmodule
bind spi_register_access_slave spi_slave_sva u_sva (.clk(clk), .nrst(nrst), .ss_n(ss_n),
  .miso(miso), .miso_oe(miso_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .cmd_strobe(cmd_strobe), .gyro_zero_strobe(gyro_zero_strobe), .gap_err(gap_err));
`default_nettype wire

//--- verification/spi_master_model.sv
// serial master driving the slave's link pins
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
  output var logic sck,
  output var logic ss_n,
  output var logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end
  task automatic sel(input logic on);
    ss_n = !on;
    mosi = 1'b1;
    #100;
  endtask
  // data set while clock low, 150 ns period
  // gap after each byte; undriven miso reads as z
  task automatic xfer(input logic [7:0] tx, input int gap, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #75 sck = 1'b1;
      rx[i] = miso_oe ? miso : 1'bz;
      #75 sck = 1'b0;
    end
    #(gap);
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the serial register access slave
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import spi_regs_pkg::*;
  // arbitrary version value
  localparam logic [31:0] FW = 32'h1234_5678;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wire logic sck, ss_n, mosi;
  logic miso, miso_oe, reg_wr, cmd_strobe, gyro_zero_strobe, gap_err;
  logic [7:0] reg_addr, a;
  logic [31:0] rd_data = 32'h0, reg_wdata, d;
  logic [43:0] e;
  logic [43:0] exp_q[$];
  logic [7:0] t[$];
  int x[$];
  int fail_count = 0, n_compared = 0, seed = 64;
  wire logic [43:0] ev = {gap_err, reg_wr, cmd_strobe, gyro_zero_strobe, reg_addr, reg_wdata};
  spi_register_access_slave #(.FW_VERSION(FW)) u_dut (.clk(clk), .nrst(nrst), .sck(sck),
    .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .reg_addr(reg_addr),
    .rd_data(rd_data), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .cmd_strobe(cmd_strobe),
    .gyro_zero_strobe(gyro_zero_strobe), .gap_err(gap_err));
  spi_master_model u_m (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  always #5 clk = ~clk;
  function automatic logic [31:0] memv(input logic [7:0] v);
    return {v, ~v, v ^ 8'h5A, 8'hC3};
  endfunction
  always @(negedge clk) rd_data <= memv(reg_addr);
  task automatic check(input string what, input logic [43:0] seen, input logic [43:0] want);
    n_compared++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask
  // gap events compare flags only, their address is meaningless
  always @(negedge clk) begin
    if (nrst && (reg_wr || cmd_strobe || gap_err)) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 44'h0;
      if (e[43]) check("gap", {40'h0, ev[43:40]}, {40'h0, e[43:40]});
      else check("event", ev, e);
    end
  end
  function automatic void add4(input logic [31:0] w);
    for (int k = 3; k >= 0; k--) x.push_back(int'(w[8*k +: 8]));
  endfunction
  task automatic frame(input string name, input int gap);
    logic [7:0] rx;
    u_m.sel(1'b1);
    foreach (t[i]) begin
      u_m.xfer(t[i], (i == 1) ? gap : 5200, rx);
      if (x[i] >= 0) check("miso", {36'h0, rx}, 44'(x[i]));
    end
    u_m.sel(1'b0);
    repeat (10) @(negedge clk);
    $display("test %s done", name);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t = {8'h01, 8'h20, 8'h11, 8'h22};
    x = {-1, -1, 0, 0};
    frame("partial", 5200);
    t = {8'h02, 8'h10, 8'h33, 8'h44};
    x = {-1, -1, 0, 0};
    frame("badop", 5200);
    // extra bytes after one register ignored
    repeat (2) begin
      a = 8'($unsigned($random(seed))) % 8'hA0;
      d = $random(seed) | 32'h1;
      exp_q.push_back({4'b0100, a, d});
      t = {8'h01, a, d[31:24], d[23:16], d[15:8], d[7:0], 8'h5A, 8'hA5};
      x = {-1, -1, 0, 0, 0, 0, -1, -1};
      frame("write", 5200);
    end
    t = {8'h00, a, 8'h00, 8'h00, 8'h00, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00};
    x = {-1, -1};
    add4(memv(a));
    add4(memv(8'h3C));
    frame("read", 5200);
    t = {8'h01, ADDR_FW_VERSION, 8'h00, 8'h00, 8'h00, 8'h00};
    x = {-1, -1};
    add4(FW);
    exp_q.push_back({4'b0010, ADDR_FW_VERSION, 32'h0});
    frame("version", 5200);
    x = {-1, -1, 0, 0, 0, 0};
    t[1] = ADDR_GYRO_ZERO;
    exp_q.push_back({4'b0011, ADDR_GYRO_ZERO, 32'h0});
    frame("gyro", 5200);
    t = {8'h00, 8'h20, 8'h00};
    x = {-1, -1, -1};
    exp_q.push_back({4'b1000, 40'h0});
    frame("gap", 1000);
    check("pending", 44'(exp_q.size()), 44'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
